// [wts_pkg.sv]
// wts_pkg: constants for the wheel tick speed input block
// assumes a single 10 MHz system clock
package wts_pkg;
    localparam int unsigned CLK_HZ          = 10000000;
    // sampling tick: the pin is looked at every SAMPLE_US microseconds
    localparam int unsigned SAMPLE_US       = 100;
    localparam int unsigned SAMPLE_CYC      = (CLK_HZ / 1000000) * SAMPLE_US;
    // measurement window in milliseconds
    localparam int unsigned WINDOW_MS       = 1000;
    localparam int unsigned WINDOW_SAMPLES  = (WINDOW_MS * 1000) / SAMPLE_US;
    localparam int unsigned WINDOW_CYC      = (CLK_HZ / 1000) * WINDOW_MS;
    // detection limits in pulses per second
    localparam int unsigned MIN_PPS         = 1;
    localparam int unsigned MAX_PPS         = 800;
    localparam int unsigned RATE_W          = 12;
    localparam int unsigned SAMPLE_CNT_W    = 16;
    localparam int unsigned WIN_CNT_W       = 16;
    localparam logic [RATE_W-1:0] RATE_RST  = 12'h000;

    typedef enum logic [1:0] {
        WTS_IDLE  = 2'h0,
        WTS_MEAS  = 2'h1,
        WTS_FLAG  = 2'h3
    } wts_state_e;
endpackage

// [wts_wheel_tick.sv]
// wts_wheel_tick: samples the speed pulse input on a timed tick, counts
// rising edges over a fixed window and reports a validated tick rate.
// assumes the pulse source keeps ~50% duty and is divided below the top rate.
`timescale 1ns/10ps
module wts_wheel_tick
    import wts_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES  = SAMPLE_CYC,
    parameter int unsigned WINDOW_SAMPLE_N = WINDOW_SAMPLES
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              speedPulseInput,
    output logic [RATE_W-1:0]      tickRate,
    output logic                   rateValid,
    output logic                   rateUpdate
);
    logic                    syncA_q;
    logic                    syncB_q;
    logic [SAMPLE_CNT_W-1:0] sampleCnt_q;
    logic [SAMPLE_CNT_W-1:0] sampleCnt_d;
    logic [WIN_CNT_W-1:0]    winCnt_q;
    logic [WIN_CNT_W-1:0]    winCnt_d;
    logic [RATE_W:0]         edgeCnt_q;
    logic [RATE_W:0]         edgeCnt_d;
    logic                    level_q;
    logic                    level_d;
    logic [RATE_W-1:0]       tickRate_q;
    logic [RATE_W-1:0]       tickRate_d;
    logic                    rateValid_q;
    logic                    rateValid_d;
    logic                    rateUpdate_q;
    wts_state_e              state_q;
    wts_state_e              state_d;
    logic                    sampleTick;
    logic                    lastSample;
    logic                    measuring;
    logic                    sampleHere;
    logic                    pinRose;
    logic                    winEnd;
    logic                    riseSeen;
    logic [RATE_W:0]         finalCnt;
    logic                    tooSlow;
    logic                    tooFast;
    logic                    resultOk;

    // saturating step of the edge count: once the top bit is set the count
    // sticks there, so a runaway train can never wrap back into the band
    function automatic logic [RATE_W:0] edgeStep(
        input logic [RATE_W:0] cnt,
        input logic            inc
    );
        logic [RATE_W:0] res;
        res = cnt;
        if (inc && !cnt[RATE_W]) begin
            res = cnt + 1'b1;
        end
        return res;
    endfunction

    // zero edges in a window means the train is slower than the low limit
    // or absent; it is reported as no reading, never as a zero speed
    function automatic logic belowBand(input logic [RATE_W:0] cnt);
        return cnt < (RATE_W+1)'(MIN_PPS);
    endfunction

    // the saturated value also lands here, whatever the true rate was
    function automatic logic aboveBand(input logic [RATE_W:0] cnt);
        return cnt > (RATE_W+1)'(MAX_PPS);
    endfunction

    // the pin is looked at only on the sample tick; a pulse phase shorter
    // than one sample period can slip between two looks and be missed
    assign sampleTick = (sampleCnt_q == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));
    assign lastSample = (winCnt_q == WIN_CNT_W'(WINDOW_SAMPLE_N - 1));
    assign measuring  = (state_q != WTS_IDLE);
    assign sampleHere = sampleTick && measuring;
    assign pinRose    = syncB_q && !level_q;
    assign winEnd     = sampleHere && lastSample;
    assign riseSeen   = sampleHere && pinRose;
    assign finalCnt   = edgeStep(edgeCnt_q, riseSeen);
    assign tooSlow    = belowBand(finalCnt);
    assign tooFast    = aboveBand(finalCnt);
    assign resultOk   = !tooSlow && !tooFast;

    // the sample timer runs free from reset; windows are whole numbers of
    // sample ticks and the closing tick still counts, so none is lost
    assign sampleCnt_d = sampleTick ? '0 : sampleCnt_q + 1'b1;
    assign level_d     = sampleTick ? syncB_q : level_q;
    assign winCnt_d    = !sampleHere ? winCnt_q
                       : lastSample ? '0 : winCnt_q + 1'b1;
    assign edgeCnt_d   = winEnd ? '0 : finalCnt;
    assign tickRate_d  = !winEnd ? tickRate_q
                       : resultOk ? finalCnt[RATE_W-1:0] : RATE_RST;
    assign rateValid_d = winEnd ? resultOk : rateValid_q;

    // the first tick after reset only seeds the level register, so a pin
    // already high when reset lifts is not taken for a rise
    always_comb begin
        state_d = state_q;
        case (state_q)
            WTS_IDLE: begin
                if (sampleTick) begin
                    state_d = WTS_MEAS;
                end
            end
            WTS_MEAS: begin
                if (winEnd) begin
                    state_d = WTS_FLAG;
                end
            end
            WTS_FLAG: begin
                // sampling carries on here; this state only marks a closed window
                if (winEnd) begin
                    state_d = WTS_FLAG;
                end else begin
                    state_d = WTS_MEAS;
                end
            end
            default: begin
                state_d = WTS_IDLE;
            end
        endcase
    end

    // every register resets asynchronously to its idle, no-reading value
    // two-stage synchroniser; only the second stage is read downstream
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
        end else begin
            syncA_q <= speedPulseInput;
            syncB_q <= syncA_q;
        end
    end

    // free-running sample timer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sampleCnt_q <= '0;
        end else begin
            sampleCnt_q <= sampleCnt_d;
        end
    end

    // position of the current sample inside the window
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            winCnt_q <= '0;
        end else begin
            winCnt_q <= winCnt_d;
        end
    end

    // rises seen so far in the open window
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            edgeCnt_q <= '0;
        end else begin
            edgeCnt_q <= edgeCnt_d;
        end
    end

    // level at the previous look; resets low, the pin's idle level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    // published result holds until the next window closes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tickRate_q <= RATE_RST;
        end else begin
            tickRate_q <= tickRate_d;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rateValid_q <= 1'b0;
        end else begin
            rateValid_q <= rateValid_d;
        end
    end

    // strobe is high in the very cycle the new result first shows, so a
    // reader may take the rate and the valid flag together with it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rateUpdate_q <= 1'b0;
        end else begin
            rateUpdate_q <= winEnd;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= WTS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs come straight from flip-flops, free of decode glitches
    assign tickRate   = tickRate_q;
    assign rateValid  = rateValid_q;
    assign rateUpdate = rateUpdate_q;
endmodule // wts_wheel_tick

// [wts_pulse_source.sv]
// wts_pulse_source: vehicle tick source, one burst of ticks per go
// assumes go is held for one clock with count stable
`timescale 1ns/10ps
module wts_pulse_source (
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [11:0] count,
    output logic             pin
);
    // 6 high then 6 low: even duty, rate just above the top limit
    initial begin
        pin = 1'b0; // idles low between bursts, as on backup power
        forever begin
            @(posedge clock);
            if (go) begin
                for (int i = 0; i < count; i++) begin
                    pin <= 1'b1;
                    repeat (6) @(posedge clock);
                    pin <= 1'b0;
                    repeat (6) @(posedge clock);
                end
            end
        end
    end
endmodule // wts_pulse_source

// [wts_wheel_tick_checker.sv]
// wts_wheel_tick_checker: port properties of the tick rate block
// assumes a bind onto wts_wheel_tick
`timescale 1ns/10ps
module wts_wheel_tick_checker
    import wts_pkg::*;
(
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic [RATE_W-1:0] tickRate,
    input wire logic              rateValid,
    input wire logic              rateUpdate
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_invalid_zero_rate: assert property (!rateValid |-> tickRate == RATE_RST)
        else $error("rate shown while invalid");
    a_slow_bound: assert property (rateValid |-> tickRate >= MIN_PPS)
        else $error("valid rate too low");
    a_fast_bound: assert property (rateValid |-> tickRate <= MAX_PPS)
        else $error("valid rate too high");
    a_update_single: assert property (rateUpdate |=> !rateUpdate)
        else $error("update too long");
    a_change_flagged: assert property (!$stable({tickRate, rateValid}) |-> rateUpdate)
        else $error("result changed silently");
    a_update_spacing: assert property (rateUpdate |=> (!rateUpdate) [*8])
        else $error("updates too close together");
endmodule // wts_wheel_tick_checker

// [testbench.sv]
// testbench: one tick burst per window, each reported rate checked
// assumes a shortened window of 10000 clocks
`timescale 1ns/10ps
module testbench
    import wts_pkg::*;
;
    logic              clock = 1'b0, rstn = 1'b0, go = 1'b0, pin, rateValid, rateUpdate;
    logic [11:0]       count = 12'h000;
    logic [RATE_W-1:0] tickRate;
    logic [RATE_W:0]   expQ[$];
    int                err_total = 0, cmp_count = 0, cycles = 0;
    always #50 clock = ~clock;
    // dead-reckoning build: the pin is always wired to a source, never left open
    wts_pulse_source src (.clock(clock), .go(go), .count(count), .pin(pin));
    wts_wheel_tick #(.SAMPLE_CYCLES(2), .WINDOW_SAMPLE_N(5000)) uut (.clock(clock), .rstn(rstn),
        .speedPulseInput(pin), .tickRate(tickRate), .rateValid(rateValid), .rateUpdate(rateUpdate));
    task automatic check_rate(input logic [RATE_W:0] exp);
        cmp_count++;
        if ({rateValid, tickRate} !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, {rateValid, tickRate}, exp);
        end
        $display("window done, rate %h", tickRate);
    endtask
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // bursts start just after an update so each lands inside one window
    task automatic burst(input logic [11:0] n);
        @(negedge clock iff rateUpdate);
        expQ.push_back((n >= MIN_PPS && n <= MAX_PPS) ? {1'b1, n} : '0);
        @(posedge clock);
        go <= 1'b1;
        count <= n;
        @(posedge clock);
        go <= 1'b0;
    endtask
    always @(negedge clock) if (rateUpdate) check_rate(expQ.pop_front());
    always @(posedge clock) if (++cycles > 90000) begin
        err_total++;
        stop_test();
    end
    initial begin
        void'($urandom(78));
        expQ.push_back('0);
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        burst(12'h000);
        burst(12'h001);
        burst(12'h320);
        burst(12'h321);
        burst(12'(2 + $urandom % 798));
        @(negedge clock iff rateUpdate);
        @(negedge clock);
        stop_test();
    end
endmodule // testbench
bind wts_wheel_tick wts_wheel_tick_checker chk (.clock(clock), .rstn(rstn), .tickRate(tickRate),
    .rateValid(rateValid), .rateUpdate(rateUpdate));
